// file: verilog/adc_ctrl_regs.svh
// Notes on behaviour
// - First one after select falls starts byte
// - Bits 6..4 choose the input channels
// - Bit 3: one unipolar, zero bipolar
// - Host pairs bipolar with differential input
// - Bit 2: one single-ended, zero differential
// - Bit 1: one operational, zero power-down
// - Bit 0: one serial clock, zero internal
// - Eight-input single-ended channel mapping
// - Eight-input differential pair and polarity
// - Four-input single-ended mapping, low select ignored
// - Four-input differential pairs, low select ignored
// - Unipolar negative difference gives code zero
// - Host sends full byte before each conversion
// - Strobe high two periods before MSB
// - Input held high: ten clocks per conversion
// - Data, and the strobe in external clock mode, change on falling edges
// - Host allows at least 1 us acquisition
// - Input sampled on rising edges, select low
// - Track after sixth bit, hold after eighth
// - Internal mode: strobe low while converting
`ifndef ADC_CTRL_REGS_SVH
`define ADC_CTRL_REGS_SVH
// control byte field positions
`define CTRL_START_POS 7
`define CTRL_SEL_HI_POS 6
`define CTRL_SEL_MID_POS 5
`define CTRL_SEL_LO_POS 4
`define CTRL_CODING_POS 3
`define CTRL_CONFIG_POS 2
`define CTRL_POWER_POS 1
`define CTRL_CLKSRC_POS 0
// power-on settings: internal clock, operational
`define CTRL_RESET 8'h02
// timing
`define CORE_PERIOD_NS 4
`define ACQ_TIME_NS 1000
`define ACQ_SCLK_HALF ((`ACQ_TIME_NS + 4 * `CORE_PERIOD_NS - 1) / (4 * `CORE_PERIOD_NS))
`define INT_CONV_NS 25000
`define INT_CONV_CYC (`INT_CONV_NS / `CORE_PERIOD_NS)
// serial frame counts
`define TRACK_BIT_CNT 4'h6
`define LAST_BIT_CNT 4'h7
`define CTRL_BITS 5'h08
`define CAPTURE_FIRST 5'h0B
`define CAPTURE_LAST 5'h12
`define FRAME_CLOCKS 5'h18
`endif

// file: verilog/adc_ctrl_pkg.sv
`default_nettype none
package adc_ctrl_pkg;
	// serial framer of the converter end
	typedef enum logic [1:0] {FR_HUNT = 2'b00, FR_CTRL = 2'b01, FR_WAIT = 2'b11} fr_state_t;
	// result path of the converter end
	typedef enum logic [2:0] {
		OUT_IDLE = 3'b000, OUT_STROBE = 3'b001, OUT_CONV = 3'b011, OUT_LEAD = 3'b010
	} out_state_t;
	// sequencer of the host end
	typedef enum logic [1:0] {H_IDLE = 2'b00, H_RUN = 2'b01, H_WAIT = 2'b11} host_state_t;
endpackage : adc_ctrl_pkg
`default_nettype wire

// file: verilog/adc_link.sv
`default_nettype none
interface adc_link;
	logic cs_n;
	logic sclk;
	logic din;
	logic dout;
	logic dout_oe;
	logic strb;
	logic strb_oe;
	logic dout_line;
	logic strb_line;
	// undriven lines read low, as a weak pull-down would leave them
	assign dout_line = dout_oe & dout;
	assign strb_line = strb_oe & strb;
	modport dev (input cs_n, input sclk, input din, output dout, output dout_oe, output strb, output strb_oe);
	modport host (output cs_n, output sclk, output din, input dout_line, input strb_line);
endinterface : adc_link
`default_nettype wire

// file: verilog/pin_sync.sv
`default_nettype none
module pin_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] INIT = '0
) (
	// clock and reset
	input wire logic CORE_CLK,
	input wire logic RSTN,
	// pins in, settled levels out
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] s1_ff;
	logic [W-1:0] s2_ff;
	logic [W-1:0] s3_ff;
	logic [W-1:0] q_ff;
	logic [W-1:0] nxt_q;

	////////////////////////////////////////////////////////////////////////
	// a level counts only once stages two and three agree, masking one-cycle glitches
	genvar i;
	for (i = 0; i < W; i++) begin : g_bit
		always_comb begin
			nxt_q[i] = (s2_ff[i] == s3_ff[i]) ? s3_ff[i] : q_ff[i];
		end
	end

	// stage one feeds stage two only
	always_ff @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN) begin
			s1_ff <= INIT;
			s2_ff <= INIT;
			s3_ff <= INIT;
			q_ff <= INIT;
		end else begin
			s1_ff <= d;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
			q_ff <= nxt_q;
		end
	end

	assign q = q_ff;
endmodule : pin_sync
`default_nettype wire

// file: verilog/adc_ctrl_dev.sv
`include "adc_ctrl_regs.svh"
`default_nettype none
module adc_ctrl_dev import adc_ctrl_pkg::*; #(
	parameter logic FOUR_INPUT = 1'b0,
	parameter int INT_CONV_CYCLES = `INT_CONV_CYC
) (
	// clock and reset
	input wire logic CORE_CLK,
	input wire logic RSTN,
	// serial link
	adc_link.dev LINK,
	// sampled analog levels
	input wire logic [7:0][7:0] ANALOG_IN,
	input wire logic [7:0] COMMON_LEVEL,
	// decoded settings
	output logic [2:0] POS_CHAN,
	output logic [2:0] NEG_CHAN,
	output logic NEG_COMMON,
	output logic UNIPOLAR,
	output logic POWER_UP,
	output logic EXT_CLOCK,
	// track/hold and result
	output logic TRACKING,
	output logic [7:0] RESULT_CODE
);
	localparam int TW = $clog2(INT_CONV_CYCLES + 1);

	logic cs_q;
	logic sclk_q;
	logic din_q;
	logic cs_prev_ff;
	logic sclk_prev_ff;
	logic sclk_rise;
	logic sclk_fall;
	logic cs_fall;
	logic cs_rise;
	fr_state_t fr_ff, nxt_fr;
	out_state_t out_ff, nxt_out;
	logic [3:0] cnt_ff, nxt_cnt;
	logic [7:0] in_sh_ff, nxt_in_sh;
	logic [7:0] cfg_ff, nxt_cfg;
	logic [6:0] map_ff, nxt_map;
	logic pend_ff, nxt_pend;
	logic track_ff, nxt_track;
	logic sub_ff, nxt_sub;
	logic [7:0] out_sh_ff, nxt_out_sh;
	logic [7:0] code_ff, nxt_code;
	logic dout_ff, nxt_dout;
	logic strb_ff, nxt_strb;
	logic [TW-1:0] timer_ff, nxt_timer;

	////////////////////////////////////////////////////////////////////////
	// channel decode: {pos, neg, neg_is_common} from select bits
	function automatic logic [6:0] chan_map(input logic [2:0] sel, input logic single, input logic four);
		logic [2:0] pos;
		logic [2:0] neg;
		pos = 3'h0;
		neg = 3'h0;
		if (four) begin
			pos = {1'b0, sel[1], sel[2]};
			neg = {1'b0, sel[1], ~sel[2]};
		end else if (single) begin
			pos = {sel[1], sel[0], sel[2]};
		end else begin
			pos = {sel[1], sel[0], sel[2]};
			neg = {sel[1], sel[0], ~sel[2]};
		end
		return {pos, neg, single};
	endfunction : chan_map

	////////////////////////////////////////////////////////////////////////
	// pins come from the host's domain, so all three pass the settling synchroniser
	pin_sync #(.W(3), .INIT(3'h4)) u_sync (
		.CORE_CLK(CORE_CLK),
		.RSTN(RSTN),
		.d({LINK.cs_n, LINK.sclk, LINK.din}),
		.q({cs_q, sclk_q, din_q})
	);

	// edges of the settled link levels
	always_comb begin
		sclk_rise = sclk_q & ~sclk_prev_ff;
		sclk_fall = ~sclk_q & sclk_prev_ff;
		cs_fall = ~cs_q & cs_prev_ff;
		cs_rise = cs_q & ~cs_prev_ff;
	end

	////////////////////////////////////////////////////////////////////////
	// framer and result sequencer next state
	always_comb begin
		logic [7:0] pv;
		logic [7:0] nv;
		logic [8:0] diff;
		pv = ANALOG_IN[map_ff[6:4]];
		nv = map_ff[0] ? COMMON_LEVEL : ANALOG_IN[map_ff[3:1]];
		diff = {1'b0, pv} - {1'b0, nv};
		nxt_fr = fr_ff;
		nxt_out = out_ff;
		nxt_cnt = cnt_ff;
		nxt_in_sh = in_sh_ff;
		nxt_cfg = cfg_ff;
		nxt_map = map_ff;
		nxt_pend = pend_ff;
		nxt_track = track_ff;
		nxt_sub = sub_ff;
		nxt_out_sh = out_sh_ff;
		nxt_code = code_ff;
		nxt_dout = dout_ff;
		nxt_strb = strb_ff;
		nxt_timer = timer_ff;
		// internal conversion runs off the core clock and ignores select
		if (out_ff == OUT_CONV) begin
			if (timer_ff == '0) begin
				nxt_strb = 1'b1;
				nxt_out = OUT_LEAD;
				nxt_sub = 1'b0;
			end else begin
				nxt_timer = timer_ff - TW'(1);
			end
		end
		if (cs_fall && cfg_ff[`CTRL_CLKSRC_POS]) begin
			nxt_strb = 1'b0;
		end
		if (cs_rise) begin
			// a select toggle aborts a frame; an internal conversion keeps going
			nxt_fr = FR_HUNT;
			nxt_cnt = 4'h0;
			nxt_pend = 1'b0;
			nxt_track = 1'b0;
			if (cfg_ff[`CTRL_CLKSRC_POS]) begin
				nxt_strb = 1'b0;
				if (out_ff != OUT_IDLE) begin
					nxt_out = OUT_IDLE;
				end
			end
		end else if (!cs_q) begin
			// input bits only on rising edges while selected
			if (sclk_rise) begin
				case (fr_ff)
					FR_HUNT: begin
						if (din_q) begin
							nxt_fr = FR_CTRL;
							nxt_in_sh = 8'h01;
							nxt_cnt = 4'h1;
						end
					end
					FR_CTRL: begin
						nxt_in_sh = {in_sh_ff[6:0], din_q};
						nxt_cnt = cnt_ff + 4'h1;
						if (cnt_ff == `LAST_BIT_CNT) begin
							// settings stand until the next full byte
							nxt_cfg = {in_sh_ff[6:0], din_q};
							nxt_map = chan_map(in_sh_ff[5:3], in_sh_ff[1], FOUR_INPUT);
							nxt_pend = 1'b1;
							nxt_fr = FR_WAIT;
							nxt_cnt = 4'h0;
						end
					end
					default: begin
					end
				endcase
			end
			// outputs only move on falling edges
			if (sclk_fall) begin
				if (fr_ff == FR_CTRL && cnt_ff == `TRACK_BIT_CNT) begin
					nxt_track = 1'b1;
				end
				if (pend_ff) begin
					// hold and start converting
					nxt_track = 1'b0;
					nxt_pend = 1'b0;
					nxt_sub = 1'b0;
					nxt_dout = 1'b0;
					if (cfg_ff[`CTRL_CODING_POS]) begin
						nxt_out_sh = diff[8] ? 8'h00 : diff[7:0];
					end else begin
						nxt_out_sh = diff[8:1];
					end
					nxt_code = nxt_out_sh;
					if (cfg_ff[`CTRL_CLKSRC_POS]) begin
						nxt_strb = 1'b1;
						nxt_out = OUT_STROBE;
					end else begin
						nxt_strb = 1'b0;
						nxt_out = OUT_CONV;
						nxt_timer = TW'(INT_CONV_CYCLES - 1);
					end
				end else begin
					case (out_ff)
						OUT_STROBE, OUT_LEAD: begin
							if (!sub_ff) begin
								nxt_sub = 1'b1;
							end else begin
								// second edge: MSB out, strobe drops in OUT_STROBE only, framer rearms
								if (out_ff == OUT_STROBE) begin
									nxt_strb = 1'b0;
								end
								nxt_dout = out_sh_ff[7];
								nxt_out_sh = {out_sh_ff[6:0], 1'b0};
								nxt_out = OUT_IDLE;
								if (fr_ff == FR_WAIT) begin
									nxt_fr = FR_HUNT;
								end
							end
						end
						OUT_IDLE: begin
							// remaining bits then zeros
							nxt_dout = out_sh_ff[7];
							nxt_out_sh = {out_sh_ff[6:0], 1'b0};
						end
						default: begin
						end
					endcase
				end
			end
		end
	end

	// state registers; power-on comes up in internal clock mode with strobe high
	always_ff @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN) begin
			cs_prev_ff <= 1'b1;
			sclk_prev_ff <= 1'b0;
			fr_ff <= FR_HUNT;
			out_ff <= OUT_IDLE;
			cnt_ff <= 4'h0;
			in_sh_ff <= 8'h00;
			cfg_ff <= `CTRL_RESET;
			map_ff <= 7'h01;
			pend_ff <= 1'b0;
			track_ff <= 1'b0;
			sub_ff <= 1'b0;
			out_sh_ff <= 8'h00;
			code_ff <= 8'h00;
			dout_ff <= 1'b0;
			strb_ff <= 1'b1;
			timer_ff <= '0;
		end else begin
			cs_prev_ff <= cs_q;
			sclk_prev_ff <= sclk_q;
			fr_ff <= nxt_fr;
			out_ff <= nxt_out;
			cnt_ff <= nxt_cnt;
			in_sh_ff <= nxt_in_sh;
			cfg_ff <= nxt_cfg;
			map_ff <= nxt_map;
			pend_ff <= nxt_pend;
			track_ff <= nxt_track;
			sub_ff <= nxt_sub;
			out_sh_ff <= nxt_out_sh;
			code_ff <= nxt_code;
			dout_ff <= nxt_dout;
			strb_ff <= nxt_strb;
			timer_ff <= nxt_timer;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// link drive: data floats when deselected, strobe floats only when deselected in external mode
	assign LINK.dout = dout_ff;
	assign LINK.dout_oe = ~cs_q;
	assign LINK.strb = strb_ff;
	assign LINK.strb_oe = ~cs_q | ~cfg_ff[`CTRL_CLKSRC_POS];

	// decoded settings
	assign POS_CHAN = map_ff[6:4];
	assign NEG_CHAN = map_ff[3:1];
	assign NEG_COMMON = map_ff[0];
	assign UNIPOLAR = cfg_ff[`CTRL_CODING_POS];
	assign POWER_UP = cfg_ff[`CTRL_POWER_POS];
	assign EXT_CLOCK = cfg_ff[`CTRL_CLKSRC_POS];
	assign TRACKING = track_ff;
	assign RESULT_CODE = code_ff;
endmodule : adc_ctrl_dev
`default_nettype wire

// file: verilog/adc_ctrl_host.sv
`include "adc_ctrl_regs.svh"
`default_nettype none
module adc_ctrl_host import adc_ctrl_pkg::*; #(
	parameter int SCLK_HALF = `ACQ_SCLK_HALF
) (
	// clock and reset
	input wire logic CORE_CLK,
	input wire logic RSTN,
	// serial link
	adc_link.host LINK,
	// user request
	input wire logic START,
	input wire logic [7:0] CTRL_BYTE,
	input wire logic FAST,
	// user answer
	output logic BUSY,
	output logic [7:0] RESULT,
	output logic RESULT_VALID
);
	logic dout_q;
	logic strb_q;
	host_state_t st_ff, nxt_st;
	logic [15:0] hc_ff, nxt_hc;
	logic [4:0] idx_ff, nxt_idx;
	logic [7:0] tx_ff, nxt_tx;
	logic [7:0] rx_ff, nxt_rx;
	logic [7:0] res_ff, nxt_res;
	logic cs_n_ff, nxt_cs_n;
	logic sclk_ff, nxt_sclk;
	logic din_ff, nxt_din;
	logic fast_ff, nxt_fast;
	logic seen_low_ff, nxt_seen_low;
	logic valid_ff, nxt_valid;
	logic [7:0] ctrl_eff;

	////////////////////////////////////////////////////////////////////////
	// returning lines cross from the converter's domain
	pin_sync #(.W(2), .INIT(2'h0)) u_sync (
		.CORE_CLK(CORE_CLK),
		.RSTN(RSTN),
		.d({LINK.dout_line, LINK.strb_line}),
		.q({dout_q, strb_q})
	);

	// start bit forced, and bipolar always goes with differential input
	always_comb begin
		ctrl_eff = CTRL_BYTE;
		ctrl_eff[`CTRL_START_POS] = 1'b1;
		if (!CTRL_BYTE[`CTRL_CODING_POS]) begin
			ctrl_eff[`CTRL_CONFIG_POS] = 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// frame sequencer: clock divider, bit shifting and result capture
	always_comb begin
		nxt_st = st_ff;
		nxt_hc = hc_ff;
		nxt_idx = idx_ff;
		nxt_tx = tx_ff;
		nxt_rx = rx_ff;
		nxt_res = res_ff;
		nxt_cs_n = cs_n_ff;
		nxt_sclk = sclk_ff;
		nxt_din = din_ff;
		nxt_fast = fast_ff;
		nxt_seen_low = seen_low_ff;
		nxt_valid = 1'b0;
		case (st_ff)
			H_IDLE: begin
				if (START) begin
					nxt_st = H_RUN;
					nxt_cs_n = 1'b0;
					nxt_din = ctrl_eff[7];
					nxt_tx = ctrl_eff;
					nxt_fast = FAST;
					nxt_idx = 5'h00;
					// half period sized so two periods of tracking cover acquisition
					nxt_hc = 16'(SCLK_HALF - 1);
				end
			end
			H_RUN: begin
				if (hc_ff != 16'h0000) begin
					nxt_hc = hc_ff - 16'h0001;
				end else begin
					nxt_hc = 16'(SCLK_HALF - 1);
					if (!sclk_ff) begin
						nxt_sclk = 1'b1;
						nxt_idx = idx_ff + 5'h01;
						if (idx_ff + 5'h01 >= `CAPTURE_FIRST && idx_ff + 5'h01 <= `CAPTURE_LAST) begin
							nxt_rx = {rx_ff[6:0], dout_q};
						end
					end else begin
						nxt_sclk = 1'b0;
						nxt_tx = {tx_ff[6:0], fast_ff};
						// fast mode holds the input high so the converter restarts every ten clocks
						nxt_din = tx_ff[6];
						if (idx_ff == `FRAME_CLOCKS) begin
							nxt_st = H_IDLE;
							nxt_cs_n = 1'b1;
							nxt_din = 1'b0;
							nxt_res = rx_ff;
							nxt_valid = 1'b1;
						// by the eighth fall the clock-source bit has shifted up to the top of the register
						end else if (idx_ff == `CTRL_BITS && !tx_ff[`CTRL_START_POS]) begin
							// internal mode: clock stays low until the strobe reports done
							nxt_st = H_WAIT;
							nxt_seen_low = 1'b0;
						end
					end
				end
			end
			H_WAIT: begin
				if (!strb_q) begin
					nxt_seen_low = 1'b1;
				end else if (seen_low_ff) begin
					nxt_st = H_RUN;
					nxt_hc = 16'(SCLK_HALF - 1);
				end
			end
			default: begin
				nxt_st = H_IDLE;
			end
		endcase
	end

	// registers; the link idles deselected with the clock low
	always_ff @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN) begin
			st_ff <= H_IDLE;
			hc_ff <= 16'h0000;
			idx_ff <= 5'h00;
			tx_ff <= 8'h00;
			rx_ff <= 8'h00;
			res_ff <= 8'h00;
			cs_n_ff <= 1'b1;
			sclk_ff <= 1'b0;
			din_ff <= 1'b0;
			fast_ff <= 1'b0;
			seen_low_ff <= 1'b0;
			valid_ff <= 1'b0;
		end else begin
			st_ff <= nxt_st;
			hc_ff <= nxt_hc;
			idx_ff <= nxt_idx;
			tx_ff <= nxt_tx;
			rx_ff <= nxt_rx;
			res_ff <= nxt_res;
			cs_n_ff <= nxt_cs_n;
			sclk_ff <= nxt_sclk;
			din_ff <= nxt_din;
			fast_ff <= nxt_fast;
			seen_low_ff <= nxt_seen_low;
			valid_ff <= nxt_valid;
		end
	end

	assign LINK.cs_n = cs_n_ff;
	assign LINK.sclk = sclk_ff;
	assign LINK.din = din_ff;
	assign BUSY = (st_ff != H_IDLE);
	assign RESULT = res_ff;
	assign RESULT_VALID = valid_ff;
endmodule : adc_ctrl_host
`default_nettype wire

// file: sim/adc_ctrl_properties.sv
`default_nettype none
module adc_ctrl_properties #(
	parameter int INT_CONV_CYCLES = 20
) (
	// clock and reset
	input wire logic CORE_CLK,
	input wire logic RSTN,
	// link wires
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic din,
	input wire logic dout,
	input wire logic dout_oe,
	input wire logic strb
);
	localparam int LOW_MIN = INT_CONV_CYCLES;
	localparam int LOW_MAX = INT_CONV_CYCLES + 7;
	logic sclk_d_ff, strb_d_ff, ext_hi_ff, nxt_ext_hi, seen_ff, nxt_seen, fall, rise, srise;
	logic [7:0] age_ff, nxt_age, sh_ff, nxt_sh;
	logic [4:0] rises_ff, nxt_rises;
	logic [3:0] hi_ff, nxt_hi, gap_ff, nxt_gap;
	logic [5:0] low_ff, nxt_low;
	////////////////////////////////////////////////////////////
	// edge ages and counts; the age saturates so idle gaps never wrap
	always_comb begin
		fall = sclk_d_ff & ~sclk;
		rise = ~sclk_d_ff & sclk;
		srise = ~strb_d_ff & strb;
		nxt_age = fall ? 8'h00 : age_ff + {7'h00, age_ff != 8'hFF};
		nxt_rises = cs_n ? 5'h00 : rises_ff + {4'h0, rise};
		nxt_sh = rise ? {sh_ff[6:0], din} : sh_ff;
		nxt_ext_hi = srise ? (age_ff < 8'h08) : (ext_hi_ff & strb);
		nxt_hi = srise ? 4'h0 : hi_ff + {3'h0, fall};
		nxt_seen = ~cs_n & ((srise & nxt_ext_hi) | seen_ff);
		nxt_gap = (cs_n | (srise & nxt_ext_hi)) ? 4'h0 : gap_ff + {3'h0, fall};
		nxt_low = (strb | fall) ? 6'h00 : low_ff + {5'h00, low_ff != 6'h3F};
	end
	// registers of the helper counters
	always_ff @(posedge CORE_CLK or negedge RSTN) begin
		if (!RSTN) begin
			// strobe idles high out of reset, so no false rise at release
			{sclk_d_ff, strb_d_ff, ext_hi_ff, seen_ff} <= 4'h4;
			{age_ff, sh_ff, rises_ff, hi_ff, gap_ff, low_ff} <= 35'h0;
		end else begin
			{sclk_d_ff, strb_d_ff, ext_hi_ff, seen_ff} <= {sclk, strb, nxt_ext_hi, nxt_seen};
			{age_ff, sh_ff, rises_ff, hi_ff, gap_ff, low_ff} <= {nxt_age, nxt_sh, nxt_rises, nxt_hi, nxt_gap, nxt_low};
		end
	end
	////////////////////////////////////////////////////////////
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (!RSTN);
	property p_start_bit;
		$fell(cs_n) |-> din ##1 (din && !sclk)[*4];
	endproperty
	property p_bip_diff;
		rises_ff == 5'h08 && $changed(rises_ff) |-> sh_ff[7] && (sh_ff[3] || !sh_ff[2]);
	endproperty
	property p_full_frame;
		$rose(cs_n) |-> rises_ff == 5'h18;
	endproperty
	property p_din_at_fall;
		$changed(din) && !cs_n && !$past(cs_n) |-> fall || age_ff < 8'h02;
	endproperty
	property p_dout_at_fall;
		dout_oe && $past(dout_oe) && $changed(dout) |-> age_ff < 8'h08;
	endproperty
	property p_strb_at_fall;
		$fell(strb) && rises_ff != 5'h00 |-> age_ff < 8'h08;
	endproperty
	property p_strobe_two;
		$fell(strb) && ext_hi_ff |-> hi_ff == 4'h2;
	endproperty
	property p_ten_clocks;
		$rose(strb) && age_ff < 8'h08 && seen_ff |-> gap_ff == 4'hA;
	endproperty
	property p_int_busy;
		$rose(strb) && age_ff > 8'h07 |-> low_ff >= 6'(LOW_MIN) && low_ff <= 6'(LOW_MAX);
	endproperty
	a_start_bit: assert property (p_start_bit) else $error("frame lacks start bit");
	a_bip_diff: assert property (p_bip_diff) else $error("bipolar byte not differential");
	a_full_frame: assert property (p_full_frame) else $error("frame clock count off");
	a_din_at_fall: assert property (p_din_at_fall) else $error("data in moved off a fall");
	a_dout_at_fall: assert property (p_dout_at_fall) else $error("data out moved off a fall");
	a_strb_at_fall: assert property (p_strb_at_fall) else $error("strobe moved off a fall");
	a_strobe_two: assert property (p_strobe_two) else $error("strobe width not two clocks");
	a_ten_clocks: assert property (p_ten_clocks) else $error("restart spacing not ten clocks");
	a_int_busy: assert property (p_int_busy) else $error("internal busy time off");
	c_ext: cover property ($rose(strb) && age_ff < 8'h08);
	c_int: cover property ($rose(strb) && age_ff > 8'h07);
	c_fast: cover property ($rose(strb) && seen_ff);
endmodule : adc_ctrl_properties
`default_nettype wire

// file: sim/adc_control_byte_decoder_test.sv
`default_nettype none
module adc_control_byte_decoder_test;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int HALF = 16;
	localparam int CONV = 20;
	logic core_clk = 1'b0;
	logic rstn = 1'b0;
	logic start = 1'b0;
	logic fast = 1'b0;
	logic [7:0] ctrl = 8'h00;
	logic [7:0] common = 8'h00;
	logic [7:0][7:0] analog = '0;
	logic busy, valid, neg_common, unipolar, power_up, ext_clock, tracking;
	logic [7:0] result, result_code;
	logic [2:0] pos_chan, neg_chan;
	logic [2:0] pos_four, neg_four;
	logic [15:0] track_cnt = 16'h0000;
	logic [15:0] track_len = 16'h0000;
	logic [7:0] corner [6] = '{8'hFF, 8'h82, 8'h8B, 8'hEF, 8'h86, 8'h81};
	int checks = 0;
	int mismatches = 0;
	int seed;
`define CHECK(a, b) begin \
	checks++; \
	if ((a) !== (b)) begin \
		mismatches++; \
		$display("wrong value at %0t: got %h want %h", $time, (a), (b)); \
	end \
end
	////////////////////////////////////////////////////////////
	adc_link link ();
	// four-input converter listens to the same host lines; its answers go nowhere
	adc_link link_four ();
	assign link_four.cs_n = link.cs_n;
	assign link_four.sclk = link.sclk;
	assign link_four.din = link.din;
	adc_ctrl_dev #(.FOUR_INPUT(1'b1), .INT_CONV_CYCLES(CONV)) u_adc_ctrl_dev_four (.CORE_CLK(core_clk), .RSTN(rstn),
		.LINK(link_four), .ANALOG_IN(analog), .COMMON_LEVEL(common), .POS_CHAN(pos_four), .NEG_CHAN(neg_four),
		.NEG_COMMON(), .UNIPOLAR(), .POWER_UP(), .EXT_CLOCK(), .TRACKING(), .RESULT_CODE());
	adc_ctrl_dev #(.FOUR_INPUT(1'b0), .INT_CONV_CYCLES(CONV)) u_adc_ctrl_dev (.CORE_CLK(core_clk), .RSTN(rstn),
		.LINK(link), .ANALOG_IN(analog), .COMMON_LEVEL(common), .POS_CHAN(pos_chan), .NEG_CHAN(neg_chan),
		.NEG_COMMON(neg_common), .UNIPOLAR(unipolar), .POWER_UP(power_up), .EXT_CLOCK(ext_clock),
		.TRACKING(tracking), .RESULT_CODE(result_code));
	adc_ctrl_host #(.SCLK_HALF(HALF)) u_adc_ctrl_host (.CORE_CLK(core_clk), .RSTN(rstn), .LINK(link),
		.START(start), .CTRL_BYTE(ctrl), .FAST(fast), .BUSY(busy), .RESULT(result), .RESULT_VALID(valid));
	adc_ctrl_properties #(.INT_CONV_CYCLES(CONV)) u_adc_ctrl_properties (.CORE_CLK(core_clk), .RSTN(rstn),
		.cs_n(link.cs_n), .sclk(link.sclk), .din(link.din), .dout(link.dout), .dout_oe(link.dout_oe),
		.strb(link.strb));
	////////////////////////////////////////////////////////////
	// 250 MHz core clock
	always #2 core_clk = ~core_clk;
	// width of each tracking window, kept until the next one ends
	always @(posedge core_clk) begin
		if (tracking === 1'b1) track_cnt <= track_cnt + 16'h0001;
		else if (track_cnt != 16'h0000) begin
			track_len <= track_cnt;
			track_cnt <= 16'h0000;
		end
	end
	// the host forces the start bit and clears single-ended on bipolar bytes
	function automatic logic [7:0] fix_byte(input logic [7:0] b);
		fix_byte = b | 8'h80;
		if (!b[3]) fix_byte[2] = 1'b0;
	endfunction : fix_byte
	// code of the selected pair as the levels stand now
	function automatic logic [7:0] want_code(input logic [7:0] b);
		logic [8:0] d;
		d = {1'b0, analog[{b[5], b[4], b[6]}]} - {1'b0, b[2] ? common : analog[{b[5], b[4], ~b[6]}]};
		want_code = b[3] ? (d[8] ? 8'h00 : d[7:0]) : d[8:1];
	endfunction : want_code
	// one conversion; fast keeps the data line high so the byte of all ones follows
	task automatic run(input logic [7:0] b, input logic f);
		logic [7:0] e, s;
		int n;
		e = fix_byte(b);
		s = f ? 8'hFF : e;
		n = 0;
		@(posedge core_clk) #1;
		start = 1'b1;
		ctrl = b;
		fast = f;
		@(posedge core_clk) #1;
		start = 1'b0;
		`CHECK(busy, 1'b1)
		while (valid !== 1'b1 && n < 8000) begin
			@(posedge core_clk) #1;
			n++;
		end
		`CHECK(valid, 1'b1)
		`CHECK(busy, 1'b0)
		`CHECK(pos_four, {1'b0, s[5], s[6]})
		if (!s[2]) `CHECK(neg_four, {1'b0, s[5], ~s[6]})
		`CHECK(result, want_code(e))
		`CHECK(result_code, want_code(s))
		`CHECK(pos_chan, {s[5], s[4], s[6]})
		if (!s[2]) `CHECK(neg_chan, {s[5], s[4], ~s[6]})
		`CHECK(neg_common, s[2])
		`CHECK(unipolar, s[3])
		`CHECK(power_up, s[1])
		`CHECK(ext_clock, s[0])
		`CHECK(track_len, 16'(4 * HALF))
		$display("test with byte %h fast %b done", e, f);
	endtask : run
	// verdict and end of run
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : give_verdict
	////////////////////////////////////////////////////////////
	// corner bytes, then every channel code in both input modes
	initial begin
		logic [3:0] i;
		logic [31:0] r;
		seed = 32'h4700;
		repeat (10) @(posedge core_clk);
		#1 rstn = 1'b1;
		repeat (10) @(posedge core_clk);
		for (int k = 0; k < 8; k++) analog[k] = 8'(16 * k + 10);
		common = 8'h05;
		for (int c = 0; c < 6; c++) run(corner[c], c == 3);
		for (int j = 0; j < 16; j++) begin
			i = 4'(j);
			r = $random(seed);
			for (int k = 0; k < 8; k++) analog[k] = 8'($random(seed));
			common = 8'($random(seed));
			run({1'b1, i[2:0], i[3] | r[3], i[3], r[1:0]}, 1'b0);
		end
		give_verdict();
	end
	// watchdog against a hung handshake
	initial begin
		#300000;
		mismatches++;
		give_verdict();
	end
endmodule : adc_control_byte_decoder_test
`default_nettype wire
